// File: pkg/sram_link_pkg.sv
/*
  Shared constants for the burst SRAM link: widths, storage depth,
  timing counts used by both ends and the byte-lane merge used by the SRAM end.
  Assumes one system clock of 8 ns; each link clock cycle spans two
  system clocks, a primary phase followed by a complement phase.
*/
package sram_link_pkg;

  // ==========================================================
  // Widths and storage
  localparam int WORD_W    = 18;
  localparam int BYTE_W    = 9;
  localparam int BYTES     = 2;
  localparam int ADDR_W    = 21;
  localparam int MEM_IDX_W = 4;
  localparam int MEM_DEPTH = 16;
  localparam int RD_PIPE   = 3;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int DLL_RST_NS      = 30;
  localparam int DLL_RST_CYC     =
    (DLL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECAL_PERIOD    = 1024;
  localparam int DLL_LOCK_CYCLES = 10240;
  localparam int CNT_W           = 16;

  typedef enum logic {
    WR_IDLE   = 1'b0,
    WR_SECOND = 1'b1
  } wr_state_e;

  // Keeps old bytes where the active-high enable is clear
  function automatic logic [WORD_W-1:0] merge_bytes(
    input logic [WORD_W-1:0] old_w,
    input logic [WORD_W-1:0] new_w,
    input logic [BYTES-1:0]  be
  );
    logic [WORD_W-1:0] res;
    res = old_w;
    for (int i = 0; i < BYTES; i++)
    begin
      if (be[i])
        res[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
    end
    return res;
  endfunction

endpackage

// File: pkg/sram_link_if.sv
/*
  Link between the memory controller end and the burst SRAM end.
  Assumes both ends share sys_clk; k_rise marks the primary phase.
*/
`timescale 1ns/100ps
interface sram_link_if (
  input wire logic sys_clk
);
  logic                               k_rise;
  logic                               clk_run;
  logic [sram_link_pkg::ADDR_W-1:0]   addr;
  logic                               read_port_select_n;
  logic                               write_port_select_n;
  logic [sram_link_pkg::BYTES-1:0]    byte_write_select_n;
  logic [sram_link_pkg::WORD_W-1:0]   d;
  logic [sram_link_pkg::WORD_W-1:0]   q;
  logic                               q_oe;
  logic                               echo_strobe_true;
  logic                               echo_strobe_comp;
  logic                               read_valid_flag;
  logic                               dll_disable_n;

  modport ctrl (
    output k_rise, clk_run, addr, read_port_select_n,
    output write_port_select_n, byte_write_select_n, d, dll_disable_n,
    input  q, q_oe, echo_strobe_true, echo_strobe_comp, read_valid_flag
  );

  modport mem (
    input  k_rise, clk_run, addr, read_port_select_n,
    input  write_port_select_n, byte_write_select_n, d, dll_disable_n,
    output q, q_oe, echo_strobe_true, echo_strobe_comp, read_valid_flag
  );
endinterface

// File: logic/burst_sram_end.sv
/*
  Burst SRAM end: separate read and write ports over one shared address
  bus, two-word bursts, byte-lane writes, write forwarding, echo strobes,
  read-valid flag, impedance recalibration tick and loop lock tracking.
  Assumes the controller end on the same sys_clk drives k_rise as a
  strict alternation while clk_run is high.
*/
// Contract
// - Loop enabled: read data two link cycles later
// - Loop disabled: legacy one link cycle latency
// - Both ports launch on primary phase
// - Data and byte selects captured on both phases
// - Each access is two 18-bit words
// - Read select low latches read address
// - Lower word primary, upper word complement phase
// - Finish reads, then release read bus
// - Write select low stores first word
// - Complement phase brings address, second word, commit
// - Deselected write port ignores its inputs
// - Byte selects sampled with each word
// - Select zero low byte, one high byte
// - Read and write ports run independently
// - Reads return newest data, forwarding writes
// - Port selects sampled only on primary phase
// - Recalibrate impedance every 1024 clock cycles
// - Free-running echo strobes follow both phases
// - Valid flag leads read data half cycle
// - Loop locks after 10240 stable cycles
// - Clock stop of 30 ns resets loop
// - Powers up deselected with bus released
`timescale 1ns/100ps
module burst_sram_end #(
  parameter int LOCK_CYCLES = sram_link_pkg::DLL_LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Link to the controller
  sram_link_if.mem  link,
  // Status
  output logic      dll_locked,
  output logic      impedance_cal
);

  localparam int W  = sram_link_pkg::WORD_W;
  localparam int IW = sram_link_pkg::MEM_IDX_W;
  localparam int NP = sram_link_pkg::RD_PIPE;
  localparam int CW = sram_link_pkg::CNT_W;
  localparam logic [CW-1:0] LOCK_MAX = CW'(LOCK_CYCLES - 1);
  localparam logic [CW-1:0] CAL_MAX  = CW'(sram_link_pkg::RECAL_PERIOD - 1);
  localparam logic [CW-1:0] STOP_MAX = CW'(sram_link_pkg::DLL_RST_CYC - 1);

  // ==========================================================
  // Phase decode
  wire            run      = link.clk_run;
  wire            k_edge   = run & link.k_rise;
  wire            kc_edge  = run & ~link.k_rise;
  wire            rd_launch = k_edge & ~link.read_port_select_n;
  wire            wr_launch = k_edge & ~link.write_port_select_n;
  wire            dll_on    = link.dll_disable_n;
  wire [IW-1:0]   addr_idx  = link.addr[IW-1:0];
  wire [1:0]      be_now    = ~link.byte_write_select_n;

  // ==========================================================
  // Storage: lower and upper word arrays
  logic [W-1:0]   mem_lo [sram_link_pkg::MEM_DEPTH];
  logic [W-1:0]   mem_hi [sram_link_pkg::MEM_DEPTH];

  // ==========================================================
  // Write port
  logic           wr_act_q;
  logic [W-1:0]   wr_d0_q;
  logic [1:0]     wr_be0_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wr_act_q <= 1'b0;
    else if (run)
      wr_act_q <= wr_launch;
  end

  // First word and its selects held from the primary phase
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_d0_q  <= 18'h00000;
      wr_be0_q <= 2'h0;
    end
    else if (wr_launch)
    begin
      wr_d0_q  <= link.d;
      wr_be0_q <= be_now;
    end
  end

  wire            commit = kc_edge & wr_act_q;

  always_ff @(posedge sys_clk)
  begin
    if (commit)
    begin
      mem_lo[addr_idx] <= sram_link_pkg::merge_bytes(
        mem_lo[addr_idx], wr_d0_q, wr_be0_q);
      mem_hi[addr_idx] <= sram_link_pkg::merge_bytes(
        mem_hi[addr_idx], link.d, be_now);
    end
  end

  // ==========================================================
  // Read port pipeline
  logic [NP-1:0]  rd_sr_q;
  logic [IW-1:0]  rd_a_q [NP];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rd_sr_q <= 3'h0;
    else if (run)
      rd_sr_q <= {rd_sr_q[NP-2:0], rd_launch};
  end

  always_ff @(posedge sys_clk)
  begin
    if (run)
      rd_a_q[0] <= addr_idx;
  end

  genvar gi;
  generate
    for (gi = 1; gi < NP; gi++)
    begin : g_rd_addr
      always_ff @(posedge sys_clk)
      begin
        if (run)
          rd_a_q[gi] <= rd_a_q[gi-1];
      end
    end
  endgenerate

  // Fetch one cycle ahead of the lower word on the bus
  wire            fetch   = dll_on ? rd_sr_q[2] : rd_sr_q[0];
  wire [IW-1:0]   fetch_a = dll_on ? rd_a_q[2] : rd_a_q[0];
  wire            fwd_hit = commit && !dll_on && (addr_idx == fetch_a);

  // Same-cycle commit not in arrays yet; loop on: it is a later write
  wire [W-1:0]    rd_lo = fwd_hit ?
    sram_link_pkg::merge_bytes(mem_lo[fetch_a], wr_d0_q, wr_be0_q) :
    mem_lo[fetch_a];
  wire [W-1:0]    rd_hi = fwd_hit ?
    sram_link_pkg::merge_bytes(mem_hi[fetch_a], link.d, be_now) :
    mem_hi[fetch_a];

  wire            flag_d = dll_on ? (rd_sr_q[1] | rd_sr_q[2]) :
                                    (rd_launch | rd_sr_q[0]);

  // ==========================================================
  // Read output registers
  logic [W-1:0]   q_q;
  logic [W-1:0]   hi_hold_q;
  logic           hi_pend_q;
  logic           q_oe_q;
  logic           flag_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q_q       <= 18'h00000;
      hi_hold_q <= 18'h00000;
      hi_pend_q <= 1'b0;
      q_oe_q    <= 1'b0;
      flag_q    <= 1'b0;
    end
    else if (run)
    begin
      flag_q <= flag_d;
      if (fetch)
      begin
        q_q       <= rd_lo;
        hi_hold_q <= rd_hi;
        hi_pend_q <= 1'b1;
        q_oe_q    <= 1'b1;
      end
      else if (hi_pend_q)
      begin
        q_q       <= hi_hold_q;
        hi_pend_q <= 1'b0;
        q_oe_q    <= 1'b1;
      end
      else
        q_oe_q <= 1'b0;
    end
  end

  // ==========================================================
  // Echo strobes, registered so they line up with the data
  logic           echo_t_q;
  logic           echo_c_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      echo_t_q <= 1'b0;
      echo_c_q <= 1'b0;
    end
    else if (run)
    begin
      echo_t_q <= ~link.k_rise;
      echo_c_q <= link.k_rise;
    end
  end

  // ==========================================================
  // Impedance recalibration tick
  logic [CW-1:0]  cal_cnt_q;
  logic           cal_pls_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cal_cnt_q <= 16'h0000;
      cal_pls_q <= 1'b0;
    end
    else
    begin
      cal_pls_q <= k_edge && (cal_cnt_q == CAL_MAX);
      if (k_edge)
        cal_cnt_q <= (cal_cnt_q == CAL_MAX) ? 16'h0000 : cal_cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // Loop lock; a long enough clock stop starts the count over
  logic [CW-1:0]  stop_cnt_q;
  logic [CW-1:0]  lock_cnt_q;
  logic           locked_q;
  wire            stop_done = ~run && (stop_cnt_q == STOP_MAX);

  always_ff @(posedge sys_clk)
  begin
    if (rst || run)
      stop_cnt_q <= 16'h0000;
    else if (stop_cnt_q != STOP_MAX)
      stop_cnt_q <= stop_cnt_q + 16'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || stop_done || !dll_on)
    begin
      lock_cnt_q <= 16'h0000;
      locked_q   <= 1'b0;
    end
    else if (k_edge && !locked_q)
    begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
      locked_q   <= (lock_cnt_q == LOCK_MAX);
    end
  end

  // ==========================================================
  // Outputs
  assign link.q                = q_q;
  assign link.q_oe             = q_oe_q;
  assign link.echo_strobe_true = echo_t_q;
  assign link.echo_strobe_comp = echo_c_q;
  assign link.read_valid_flag  = flag_q;
  assign dll_locked            = locked_q;
  assign impedance_cal         = cal_pls_q;

endmodule

// File: logic/sram_ctrl_end.sv
/*
  Memory controller end: makes the link phases, launches reads and
  writes on the primary phase, waits out loop lock and resets the loop
  by stopping the link clock. Assumes the SRAM end on the same sys_clk.
*/
`timescale 1ns/100ps
module sram_ctrl_end #(
  parameter int LOCK_CYCLES = sram_link_pkg::DLL_LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  // Link to the SRAM
  sram_link_if.ctrl                             link,
  // Mode and loop control
  input  wire logic                             dll_enable,
  input  wire logic                             dll_reset_req,
  output logic                                  link_ready,
  // Requests
  input  wire logic                             rd_req,
  input  wire logic [sram_link_pkg::ADDR_W-1:0] rd_addr,
  input  wire logic                             wr_req,
  input  wire logic [sram_link_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [2*sram_link_pkg::WORD_W-1:0] wr_data,
  input  wire logic [2*sram_link_pkg::BYTES-1:0]  wr_byte_en,
  // Read answer
  output logic [2*sram_link_pkg::WORD_W-1:0]    rd_data,
  output logic                                  rd_data_valid
);

  localparam int W  = sram_link_pkg::WORD_W;
  localparam int AW = sram_link_pkg::ADDR_W;
  localparam int CW = sram_link_pkg::CNT_W;
  localparam logic [CW-1:0] LOCK_MAX = CW'(LOCK_CYCLES - 1);
  localparam logic [CW-1:0] STOP_LEN = CW'(sram_link_pkg::DLL_RST_CYC);

  // ==========================================================
  // Phase, clock stop and lock wait
  logic            phase_q;
  logic            run_q;
  logic [CW-1:0]   stop_cnt_q;
  logic [CW-1:0]   lock_cnt_q;
  logic            locked_q;
  logic            ready_q;
  logic            dll_n_q;
  sram_link_pkg::wr_state_e wst_q;

  wire             lock_ok  = ~dll_enable | locked_q;
  // Only stop between bursts so no write is split by the stop
  wire             do_stop  = dll_reset_req & run_q & ~phase_q &
                              (wst_q == sram_link_pkg::WR_IDLE);
  wire             take     = ready_q & ~do_stop;
  wire             rd_take  = take & rd_req;
  wire             wr_take  = take & wr_req;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      phase_q    <= 1'b0;
      run_q      <= 1'b1;
      stop_cnt_q <= 16'h0000;
      dll_n_q    <= 1'b0;
    end
    else
    begin
      dll_n_q <= dll_enable;
      if (do_stop)
      begin
        run_q      <= 1'b0;
        stop_cnt_q <= STOP_LEN - 16'h0001;
      end
      else if (!run_q)
      begin
        if (stop_cnt_q == 16'h0000)
          run_q <= 1'b1;
        else
          stop_cnt_q <= stop_cnt_q - 16'h0001;
      end
      else
        phase_q <= ~phase_q;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || !run_q || !dll_enable)
    begin
      lock_cnt_q <= 16'h0000;
      locked_q   <= 1'b0;
    end
    else if (phase_q && !locked_q)
    begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
      locked_q   <= (lock_cnt_q == LOCK_MAX);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ready_q <= 1'b0;
    else
      ready_q <= run_q & phase_q & lock_ok & ~do_stop;
  end

  // ==========================================================
  // Launch registers
  logic [AW-1:0]   addr_q;
  logic [AW-1:0]   wr_addr_q;
  logic            rsel_n_q;
  logic            wsel_n_q;
  logic [1:0]      msk_n_q;
  logic [1:0]      msk_hi_n_q;
  logic [W-1:0]    d_q;
  logic [W-1:0]    d_hi_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rsel_n_q   <= 1'b1;
      wsel_n_q   <= 1'b1;
      wst_q      <= sram_link_pkg::WR_IDLE;
      addr_q     <= 21'h000000;
      wr_addr_q  <= 21'h000000;
      msk_n_q    <= 2'h3;
      msk_hi_n_q <= 2'h3;
      d_q        <= 18'h00000;
      d_hi_q     <= 18'h00000;
    end
    else
    begin
      rsel_n_q <= ~rd_take;
      wsel_n_q <= ~wr_take;
      case (wst_q)
        sram_link_pkg::WR_IDLE:
        begin
          if (rd_take)
            addr_q <= rd_addr;
          if (wr_take)
          begin
            d_q        <= wr_data[W-1:0];
            msk_n_q    <= ~wr_byte_en[1:0];
            d_hi_q     <= wr_data[2*W-1:W];
            msk_hi_n_q <= ~wr_byte_en[3:2];
            wr_addr_q  <= wr_addr;
            wst_q      <= sram_link_pkg::WR_SECOND;
          end
        end
        sram_link_pkg::WR_SECOND:
        begin
          addr_q  <= wr_addr_q;
          d_q     <= d_hi_q;
          msk_n_q <= msk_hi_n_q;
          wst_q   <= sram_link_pkg::WR_IDLE;
        end
        default:
          wst_q <= sram_link_pkg::WR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Read capture: lower word with the true strobe, upper with comp
  logic [W-1:0]    lo_q;
  logic [2*W-1:0]  rd_data_q;
  logic            rd_valid_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lo_q       <= 18'h00000;
      rd_data_q  <= 36'h000000000;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= link.q_oe & link.echo_strobe_comp;
      if (link.q_oe && link.echo_strobe_true)
        lo_q <= link.q;
      if (link.q_oe && link.echo_strobe_comp)
        rd_data_q <= {link.q, lo_q};
    end
  end

  // ==========================================================
  // Outputs
  assign link.k_rise              = phase_q;
  assign link.clk_run             = run_q;
  assign link.addr                = addr_q;
  assign link.read_port_select_n  = rsel_n_q;
  assign link.write_port_select_n = wsel_n_q;
  assign link.byte_write_select_n = msk_n_q;
  assign link.d                   = d_q;
  assign link.dll_disable_n       = dll_n_q;
  assign link_ready               = ready_q;
  assign rd_data                  = rd_data_q;
  assign rd_data_valid            = rd_valid_q;

endmodule

// File: testbench/sram_link_asserts.sv
/*
  Concurrent checks on the burst SRAM link signals.
  Assumes instantiation beside the link interface, all in sys_clk.
*/
`timescale 1ns/100ps
module sram_link_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link signals
  input wire logic k_rise,
  input wire logic clk_run,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic q_oe,
  input wire logic echo_strobe_true,
  input wire logic echo_strobe_comp,
  input wire logic read_valid_flag,
  input wire logic dll_disable_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Launch side
  sel_primary_a: assert property (
    (!read_port_select_n || !write_port_select_n) |-> k_rise && clk_run)
    else $error("select low outside a running primary phase");
  wr_second_a: assert property (
    !write_port_select_n |=> write_port_select_n && !k_rise)
    else $error("write second half not in complement phase");
  powerup_a: assert property (
    $fell(rst) |-> read_port_select_n && write_port_select_n && !q_oe)
    else $error("link not idle after reset");

  // ==========================================================
  // Read answer
  lat_on_a: assert property (
    (!read_port_select_n && dll_disable_n) |-> ##4 (q_oe && echo_strobe_true))
    else $error("loop-on read word not two link cycles late");
  lat_off_a: assert property (
    (!read_port_select_n && !dll_disable_n) |-> ##2 (q_oe && echo_strobe_true))
    else $error("legacy read word not one link cycle late");
  burst_two_a: assert property (
    $rose(q_oe) |-> echo_strobe_true ##1 (q_oe && echo_strobe_comp))
    else $error("read burst words out of phase");
  flag_lead_a: assert property (
    $rose(q_oe) |-> read_valid_flag && $past(read_valid_flag))
    else $error("valid flag did not lead read data");
  flag_data_a: assert property (
    $rose(read_valid_flag) |=> q_oe)
    else $error("valid flag without following data");
  release_a: assert property (
    q_oe |-> $past(read_valid_flag))
    else $error("read bus driven with no pending read");
  echo_excl_a: assert property (
    clk_run |=> echo_strobe_true == !$past(k_rise) &&
      echo_strobe_comp == $past(k_rise))
    else $error("echo strobes not following the link phases");
endmodule

// File: testbench/separate_io_ddr_burst_sram_test.sv
/*
  Self-checking bench: controller end and SRAM end joined by the link,
  random and corner-case traffic in both latency modes.
  Assumes package, interface and both ends are compiled first.
*/
`timescale 1ns/100ps
module separate_io_ddr_burst_sram_test;
  localparam int LOCK = 8;
  localparam int W    = sram_link_pkg::WORD_W;
  localparam int DW   = 2 * W;
  localparam int AW   = sram_link_pkg::ADDR_W;

  // ==========================================================
  // Signals and bench state
  logic           sys_clk;
  logic           rst;
  logic           dll_enable;
  logic           dll_reset_req;
  logic           link_ready;
  logic           rd_req;
  logic           wr_req;
  logic [AW-1:0]  rd_addr;
  logic [AW-1:0]  wr_addr;
  logic [DW-1:0]  wr_data;
  logic [3:0]     wr_byte_en;
  logic [DW-1:0]  rd_data;
  logic           rd_data_valid;
  logic           dll_locked;
  logic           impedance_cal;
  logic [W-1:0]   mem_lo [16];
  logic [W-1:0]   mem_hi [16];
  logic [DW-1:0]  exp_q [$];
  logic [AW-1:0]  last_ra;
  logic [AW-1:0]  last_wa;
  logic [DW-1:0]  last_wd;
  logic [3:0]     last_be;
  logic           wr_half;
  logic           cal_seen;
  int             num_errors;
  int             n_tests;
  int             cycles;
  int             cal_cnt;
  int             stop_cnt;

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Ends and checker
  sram_link_if link (.sys_clk(sys_clk));
  burst_sram_end #(.LOCK_CYCLES(LOCK)) i_burst_sram_end (
    .sys_clk(sys_clk), .rst(rst), .link(link.mem),
    .dll_locked(dll_locked), .impedance_cal(impedance_cal));
  sram_ctrl_end #(.LOCK_CYCLES(LOCK)) i_sram_ctrl_end (
    .sys_clk(sys_clk), .rst(rst), .link(link.ctrl),
    .dll_enable(dll_enable), .dll_reset_req(dll_reset_req),
    .link_ready(link_ready), .rd_req(rd_req), .rd_addr(rd_addr),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_byte_en(wr_byte_en), .rd_data(rd_data),
    .rd_data_valid(rd_data_valid));
  sram_link_asserts chk (
    .sys_clk(sys_clk), .rst(rst), .k_rise(link.k_rise),
    .clk_run(link.clk_run), .q_oe(link.q_oe),
    .read_port_select_n(link.read_port_select_n),
    .write_port_select_n(link.write_port_select_n),
    .echo_strobe_true(link.echo_strobe_true),
    .echo_strobe_comp(link.echo_strobe_comp),
    .read_valid_flag(link.read_valid_flag),
    .dll_disable_n(link.dll_disable_n));

  // ==========================================================
  // Helpers
  function automatic logic [W-1:0] lane_mix(input logic [W-1:0] old_w,
    input logic [W-1:0] new_w, input logic [1:0] en);
    lane_mix = old_w;
    if (en[0])
      lane_mix[8:0] = new_w[8:0];
    if (en[1])
      lane_mix[17:9] = new_w[17:9];
  endfunction

  function automatic logic [DW-1:0] rand_word();
    return {4'($urandom), $urandom};
  endfunction

  task automatic check(input logic [DW-1:0] seen,
    input logic [DW-1:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  // Waits for the ready slot, presents its read and write requests together, updates the model
  task automatic do_op(input logic rd, input logic [AW-1:0] ra,
    input logic wr, input logic [AW-1:0] wa,
    input logic [DW-1:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    while (link_ready !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    check(DW'(link_ready === 1'b1), DW'(1), "ready wait");
    rd_req = rd;
    rd_addr = ra;
    wr_req = wr;
    wr_addr = wa;
    wr_data = wd;
    wr_byte_en = be;
    tick(1);
    rd_req = 1'b0;
    wr_req = 1'b0;
    if (wr)
    begin
      last_wa = wa;
      last_wd = wd;
      last_be = be;
      mem_lo[wa[3:0]] = lane_mix(mem_lo[wa[3:0]], wd[W-1:0], be[1:0]);
      mem_hi[wa[3:0]] = lane_mix(mem_hi[wa[3:0]], wd[DW-1:W], be[3:2]);
    end
    if (rd)
    begin
      last_ra = ra;
      exp_q.push_back({mem_hi[ra[3:0]], mem_lo[ra[3:0]]});
    end
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 100)
    begin
      tick(1);
      n++;
    end
    check(DW'(exp_q.size()), DW'(0), "reads lost");
    tick(4);
  endtask

  task automatic do_reset(input logic en);
    int n;
    rst = 1'b1;
    dll_enable = en;
    tick(10);
    rst = 1'b0;
    n = 0;
    while (link_ready !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    check(DW'(n >= 2 * LOCK), DW'(en), "lock wait");
    check(DW'(link.dll_disable_n), DW'(en), "loop mode pin");
    check(DW'(dll_locked), DW'(en), "loop locked");
  endtask

  task automatic run_suite();
    for (int i = 0; i < 16; i++)
      do_op(1'b0, '0, 1'b1, AW'(i), rand_word(), 4'hF);
    // Every lane mask, read colliding with the write, then read next slot
    for (int b = 0; b < 16; b++)
    begin
      do_op(1'b1, AW'(b), 1'b1, AW'(b), rand_word(), 4'(b));
      do_op(1'b1, AW'(b), 1'b0, '0, '0, 4'h0);
    end
    // Loop reset only between bursts, so nothing is in flight
    drain();
    stop_cnt = 0;
    dll_reset_req = 1'b1;
    tick(6);
    dll_reset_req = 1'b0;
    tick(6);
    check(DW'(stop_cnt >= sram_link_pkg::DLL_RST_CYC), DW'(1),
      "clock stop");
    for (int i = 0; i < 150; i++)
    begin
      tick($urandom_range(0, 2));
      do_op(1'($urandom), AW'($urandom), 1'($urandom), AW'($urandom),
        rand_word(), 4'($urandom));
    end
    drain();
  endtask

  // ==========================================================
  // Monitors and run limit
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      $display("MISMATCH %0t run too long", $time);
      test_done();
    end
    if (link.clk_run === 1'b0)
      stop_cnt++;
    if (rd_data_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(rd_data, {DW{1'bx}}, "unrequested read");
      else
        check(rd_data, exp_q.pop_front(), "read data");
    end
    if (link.read_port_select_n === 1'b0)
      check(DW'(link.addr), DW'(last_ra), "read address");
    if (rst)
      wr_half = 1'b0;
    else if (link.write_port_select_n === 1'b0)
    begin
      check(DW'({link.byte_write_select_n, lane_mix('0, link.d,
        ~link.byte_write_select_n)}), DW'({~last_be[1:0],
        lane_mix('0, last_wd[W-1:0], last_be[1:0])}), "first word");
      wr_half = 1'b1;
    end
    else if (wr_half)
    begin
      check(DW'({link.byte_write_select_n, lane_mix('0, link.d,
        ~link.byte_write_select_n)}), DW'({~last_be[3:2],
        lane_mix('0, last_wd[DW-1:W], last_be[3:2])}), "second");
      check(DW'(link.addr), DW'(last_wa), "write address");
      wr_half = 1'b0;
    end
    if (rst)
      cal_seen = 1'b0;
    else if (impedance_cal === 1'b1)
    begin
      if (cal_seen)
        check(DW'(cal_cnt), DW'(sram_link_pkg::RECAL_PERIOD),
          "recal interval");
      cal_seen = 1'b1;
      cal_cnt = 0;
    end
    if (link.k_rise === 1'b1 && link.clk_run === 1'b1)
      cal_cnt++;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    cal_cnt = 0;
    stop_cnt = 0;
    wr_half = 1'b0;
    cal_seen = 1'b0;
    last_ra = '0;
    last_wa = '0;
    last_wd = '0;
    last_be = 4'h0;
    dll_reset_req = 1'b0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    rd_addr = '0;
    wr_addr = '0;
    wr_data = '0;
    wr_byte_en = 4'h0;
    void'($urandom(32'h2BA45B41));
    do_reset(1'b1);
    run_suite();
    do_reset(1'b0);
    run_suite();
    // Long idle so two recalibration pulses are seen
    tick(4400);
    test_done();
  end
endmodule
